// File: rtl/mpl_pkg.sv
// constants and types shared by the motor protection lockout block
package mpl_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    // minute tick and the current-loss delay
    localparam int unsigned MINUTE_S = 60;
    localparam int unsigned CUR_LOSS_DELAY_S = 3;
    localparam int unsigned MIN_INTERVAL_MAX = 60;
    localparam logic [7:0] PROT_EN_RESET = 8'hFF;
    localparam logic [3:0] AUX_FUNC_SHUNT = 4'h7;
    // enable bit positions
    localparam int unsigned BIT_ROT_EN = 0;
    localparam int unsigned BIT_SEQ_ABC = 1;
    localparam int unsigned BIT_CUR_LOSS = 2;
    localparam int unsigned BIT_SHORT_SCR = 3;
    localparam int unsigned BIT_SHUNT = 4;
    localparam int unsigned BIT_PTC = 5;
    localparam int unsigned BIT_LINE_LOSS = 6;
    localparam int unsigned BIT_RESERVED = 7;
endpackage : mpl_pkg

// File: rtl/mpl_sec_timer.sv
// second tick divider with a clearable cycle counter
`timescale 1ns/1ns
module mpl_sec_timer #(
    parameter int unsigned CYC_PER_SEC = mpl_pkg::CLK_HZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clear,
    output logic sec_tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } mpl_st_t;
    mpl_st_t s;
    mpl_st_t next_s;

    // restart the second on clear so intervals start exactly at the event
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (clear) begin
            next_s.cnt = 32'h0;
        end else if (s.cnt == 32'(CYC_PER_SEC - 1)) begin
            next_s.cnt = 32'h0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sec_tick = s.tick;
endmodule : mpl_sec_timer

// File: rtl/mpl_lockout.sv
// protection and restart lockout logic of a solid-state motor starter
//
// Contract
// - restart refused until interval minutes pass
// - interval measured start command to start
// - eight bit enable byte, default 255
// - bit 1 trips on wrong rotation
// - bit 2 picks ABC, ignored rotation off
// - bit 4 trips low current after 3s
// - bit 8 shorted SCR locks next start
// - shorted SCR judged only while off
// - bit 16 trips on current when off
// - shunt trip drives aux relay function 7
// - bit 32 trips on hot or open PTC
// - bit 64 inhibits start without line phase
// - line loss clears when all phases present
// - three wire needs fresh start after clear
// - two wire resumes with maintained start
// - three wire start during lockout not latched
// - bit 128 reserved, no feature
`timescale 1ns/1ns
module mpl_lockout #(
    parameter int unsigned CYC_PER_SEC = mpl_pkg::CLK_HZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] prot_en_wdata,
    input wire logic prot_en_we,
    output logic [7:0] protection_enable_byte,
    input wire logic [5:0] min_start_interval_lockout,
    input wire logic [3:0] aux_relay_assignment,
    input wire logic three_wire,
    input wire logic start_cmd,
    input wire logic stop_cmd,
    input wire logic fault_reset,
    input wire logic seq_abc_meas,
    input wire logic cur_low_any,
    input wire logic cur_present_any,
    input wire logic scr_shorted,
    input wire logic ptc_over,
    input wire logic line_ok_all,
    input wire logic bypass,
    output logic run,
    output logic trip,
    output logic [5:0] trip_cause,
    output logic interval_lock,
    output logic scr_lock,
    output logic line_loss,
    output logic aux_relay
);
    typedef struct packed {
        logic [7:0] en;
        logic [1:0] start_sync0;
        logic [1:0] start_sync1;
        logic [7:0] sync0;
        logic [7:0] sync1;
        logic start_prev;
        logic run;
        logic [5:0] trip;
        logic scr_lock;
        logic line_loss;
        logic lock_act;
        logic [5:0] min_cnt;
        logic [5:0] lim;
        logic [5:0] sec_cnt;
        logic [1:0] cur_sec;
        logic cur_armed;
        logic aux;
    } mpl_s_t;
    mpl_s_t s;
    mpl_s_t next_s;

    logic sec_tick;
    logic clr_sec;
    logic rot_bad, start_edge, start_lvl, stop_lvl;
    logic seq_s, low_s, curp_s, scr_s, ptc_s, line_s, byp_s, rst_s;

    mpl_sec_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_sec (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(clr_sec),
        .sec_tick(sec_tick)
    );

    // synchronised pin views, second stage only
    assign start_lvl = s.start_sync1[0];
    assign stop_lvl = s.start_sync1[1];
    assign {seq_s, low_s, curp_s, scr_s, ptc_s, line_s, byp_s, rst_s} = s.sync1;
    assign start_edge = start_lvl & ~s.start_prev;
    // wrong rotation only matters when checked against the chosen order
    assign rot_bad = seq_s != s.en[mpl_pkg::BIT_SEQ_ABC];
    // restart the second only on an accepted start, 2-wire level starts too
    assign clr_sec = next_s.run & ~s.run;

    always_comb begin
        next_s = s;
        next_s.start_sync0 = {stop_cmd, start_cmd};
        next_s.start_sync1 = s.start_sync0;
        next_s.sync0 = {seq_abc_meas, cur_low_any, cur_present_any, scr_shorted,
            ptc_over, line_ok_all, bypass, fault_reset};
        next_s.sync1 = s.sync0;
        next_s.start_prev = start_lvl;
        // all eight bits stored; bit 7 steers nothing
        if (prot_en_we) begin
            next_s.en = prot_en_wdata;
        end
        // minute counting of the start-to-start interval
        if (sec_tick && s.lock_act) begin
            if (s.sec_cnt == 6'(mpl_pkg::MINUTE_S - 1)) begin
                next_s.sec_cnt = 6'h0;
                next_s.min_cnt = s.min_cnt + 6'h1;
                if (s.min_cnt + 6'h1 >= s.lim) begin
                    next_s.lock_act = 1'b0;
                end
            end else begin
                next_s.sec_cnt = s.sec_cnt + 6'h1;
            end
        end
        // running current loss window
        if (sec_tick && s.run && !s.cur_armed) begin
            next_s.cur_sec = s.cur_sec + 2'h1;
            if (s.cur_sec == 2'(mpl_pkg::CUR_LOSS_DELAY_S - 1)) begin
                next_s.cur_armed = 1'b1;
            end
        end
        // fault reset clears latches first; events below re-set them, so set wins
        if (rst_s && !s.run) begin
            next_s.trip = 6'h0;
            next_s.scr_lock = 1'b0;
        end
        // line phase loss follows line level, self clearing
        next_s.line_loss = s.en[mpl_pkg::BIT_LINE_LOSS] & ~line_s;
        // shorted SCR evaluated only while off and not bypassed
        if (!s.run && !byp_s && scr_s && s.en[mpl_pkg::BIT_SHORT_SCR]) begin
            next_s.scr_lock = 1'b1;
        end
        // trips: current enables gate each new assertion
        if (s.run && s.en[mpl_pkg::BIT_ROT_EN] && rot_bad) begin
            next_s.trip[0] = 1'b1;
        end
        if (s.run && s.cur_armed && s.en[mpl_pkg::BIT_CUR_LOSS] && low_s) begin
            next_s.trip[1] = 1'b1;
        end
        if (!s.run && s.en[mpl_pkg::BIT_SHUNT] && curp_s) begin
            next_s.trip[2] = 1'b1;
        end
        if (s.en[mpl_pkg::BIT_PTC] && ptc_s) begin
            next_s.trip[3] = 1'b1;
        end
        // shunt trip energises aux relay when assigned
        next_s.aux = (s.trip[2] | next_s.trip[2]) &&
            (aux_relay_assignment == mpl_pkg::AUX_FUNC_SHUNT);
        // run control
        if (s.run) begin
            if (stop_lvl || (|s.trip) || (!three_wire && !start_lvl) || s.line_loss) begin
                next_s.run = 1'b0;
                next_s.cur_armed = 1'b0;
                next_s.cur_sec = 2'h0;
            end
        end else if (!(|s.trip) && !s.scr_lock && !s.line_loss && !s.lock_act &&
                (three_wire ? start_edge : start_lvl) && !stop_lvl) begin
            // 3-wire needs an edge, so lockout starts never seal in
            next_s.run = 1'b1;
            next_s.cur_sec = 2'h0;
            next_s.cur_armed = 1'b0;
            // interval runs from this start regardless of run time
            if (min_start_interval_lockout != 6'h0 &&
                    min_start_interval_lockout <= 6'(mpl_pkg::MIN_INTERVAL_MAX)) begin
                next_s.lock_act = 1'b1;
                next_s.lim = min_start_interval_lockout;
                next_s.min_cnt = 6'h0;
                next_s.sec_cnt = 6'h0;
            end
            if (s.scr_lock) begin
                next_s.run = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s <= '0;
            s.en <= mpl_pkg::PROT_EN_RESET;
            // line sync starts healthy, so no false loss flag right after reset
            s.sync0[2] <= 1'b1;
            s.sync1[2] <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign protection_enable_byte = s.en;
    assign run = s.run;
    assign trip = |s.trip;
    assign trip_cause = s.trip;
    assign interval_lock = s.lock_act;
    assign scr_lock = s.scr_lock;
    assign line_loss = s.line_loss;
    assign aux_relay = s.aux;

    a_scr_off_only: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.scr_lock) |-> $past(!s.run)) else $error("scr lock set while running");
    a_no_start_locked: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.run) |-> $past(!s.lock_act && !s.line_loss && !s.scr_lock))
        else $error("start while locked");
    a_line_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (line_s && s.line_loss) |=> !s.line_loss) else $error("line loss stuck");
    a_shunt_relay: assert property (@(posedge ref_clk) disable iff (rst)
        (s.trip[2] && aux_relay_assignment == 4'h7) |=> s.aux)
        else $error("aux relay missing");
    a_rot_disabled: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.trip[0]) |-> $past(s.en[0])) else $error("rotation trip while off");
    a_ptc_ignored: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.trip[3]) |-> $past(s.en[5] && ptc_s)) else $error("ptc trip cause");
    a_three_wire_edge: assert property (@(posedge ref_clk) disable iff (rst)
        ($rose(s.run) && three_wire) |-> $past(start_edge)) else $error("no fresh start");
    a_cur_delay: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.trip[1]) |-> $past(s.cur_armed && s.en[2])) else $error("early loss trip");
    a_reset_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
        (rst_s && !s.run && s.en[5] && ptc_s) |=> s.trip[3]) else $error("ptc trip lost");
    c_start: cover property (@(posedge ref_clk) $rose(s.run));
    c_lock_end: cover property (@(posedge ref_clk) $fell(s.lock_act));
    c_line_loss: cover property (@(posedge ref_clk) $rose(s.line_loss));
    c_shunt: cover property (@(posedge ref_clk) $rose(s.aux));
endmodule : mpl_lockout

// File: sim/mpl_operator.sv
// start command source: held level in 2-wire, pushbutton pulse in 3-wire
`timescale 1ns/1ns
module mpl_operator (
    input wire logic ref_clk,
    input wire logic three_wire,
    input wire logic want_run,
    input wire logic press,
    output logic start_cmd
);
    logic [2:0] hold = 3'h0;
    // a press lasts five cycles so the two-flop synchroniser cannot miss it
    always_ff @(posedge ref_clk) begin
        if (press) begin
            hold <= 3'h5;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end
    // 3-wire only ever gives fresh presses, never a held level
    assign start_cmd = three_wire ? (hold != 3'h0) : want_run;
endmodule : mpl_operator

// File: sim/testbench.sv
// self-checking bench for the protection and lockout block
`timescale 1ns/1ns
module testbench;
    logic ref_clk = 1'b0, rst = 1'b1, prot_en_we = 1'b0, three_wire = 1'b1, stop_cmd = 1'b0;
    logic fault_reset = 1'b0, seq_abc_meas = 1'b1, cur_low_any = 1'b0, cur_present_any = 1'b0;
    logic scr_shorted = 1'b0, ptc_over = 1'b0, line_ok_all = 1'b1, bypass = 1'b0;
    logic want_run = 1'b0, press = 1'b0, start_cmd, run, trip, interval_lock, scr_lock;
    logic line_loss, aux_relay;
    logic [7:0] prot_en_wdata = 8'h00, protection_enable_byte, v;
    logic [5:0] min_start_interval_lockout = 6'h00, trip_cause;
    logic [3:0] aux_relay_assignment = 4'h7;
    logic [31:0] seed = 32'hF75BDACD;
    int n_fail = 0, samples_checked = 0;
    mpl_lockout #(.CYC_PER_SEC(10)) mpl_lockout_i (.ref_clk(ref_clk), .rst(rst),
        .prot_en_wdata(prot_en_wdata), .prot_en_we(prot_en_we),
        .protection_enable_byte(protection_enable_byte),
        .min_start_interval_lockout(min_start_interval_lockout),
        .aux_relay_assignment(aux_relay_assignment), .three_wire(three_wire),
        .start_cmd(start_cmd), .stop_cmd(stop_cmd), .fault_reset(fault_reset),
        .seq_abc_meas(seq_abc_meas), .cur_low_any(cur_low_any),
        .cur_present_any(cur_present_any), .scr_shorted(scr_shorted), .ptc_over(ptc_over),
        .line_ok_all(line_ok_all), .bypass(bypass), .run(run), .trip(trip),
        .trip_cause(trip_cause), .interval_lock(interval_lock), .scr_lock(scr_lock),
        .line_loss(line_loss), .aux_relay(aux_relay));
    mpl_operator mpl_operator_i (.ref_clk(ref_clk), .three_wire(three_wire),
        .want_run(want_run), .press(press), .start_cmd(start_cmd));
    // 250 MHz
    always #2 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // expected cause vector: one bit per trip source
    function automatic logic [7:0] cause(input int b);
        return 8'h01 << b;
    endfunction : cause
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic chk_bit(input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_bit
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_byte
    task automatic wr_en(input logic [7:0] d);
        prot_en_wdata <= d;
        prot_en_we <= 1'b1;
        cyc(1);
        prot_en_we <= 1'b0;
        cyc(2);
    endtask : wr_en
    localparam int PIN_PRESS = 0;
    localparam int PIN_STOP = 1;
    localparam int PIN_FRESET = 2;
    localparam int PIN_SCR = 3;
    // selector instead of a reference argument, so the pin keeps its nonblocking drive
    task automatic drive_pin(input int k, input logic v);
        case (k)
            PIN_PRESS: press <= v;
            PIN_STOP: stop_cmd <= v;
            PIN_FRESET: fault_reset <= v;
            default: scr_shorted <= v;
        endcase
    endtask : drive_pin
    // pin pulses are held a few cycles so the synchroniser sees them
    task automatic pulse(input int k);
        drive_pin(k, 1'b1);
        cyc(4);
        drive_pin(k, 1'b0);
        cyc(8);
    endtask : pulse
    task automatic close_out();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        #40000;
        n_fail++;
        close_out();
    end
    initial begin
        cyc(3);
        rst <= 1'b0;
        cyc(4);
        chk_byte(8'hFF, protection_enable_byte);
        for (int i = 0; i < 4; i++) begin
            v = xs();
            wr_en(v);
            chk_byte(v, protection_enable_byte);
        end
        wr_en(8'h7F);
        min_start_interval_lockout <= 6'h01;
        pulse(PIN_PRESS);
        chk_bit(1'b1, run);
        chk_bit(1'b1, interval_lock);
        pulse(PIN_STOP);
        pulse(PIN_PRESS);
        chk_bit(1'b0, run);
        cyc(600);
        min_start_interval_lockout <= 6'h00;
        chk_bit(1'b0, interval_lock);
        chk_bit(1'b0, run);
        pulse(PIN_PRESS);
        chk_bit(1'b1, run);
        seq_abc_meas <= 1'b0;
        cyc(8);
        chk_byte(cause(0), {2'h0, trip_cause});
        seq_abc_meas <= 1'b1;
        pulse(PIN_FRESET);
        wr_en(8'h7C);
        pulse(PIN_PRESS);
        cyc(8);
        chk_byte(8'h00, {2'h0, trip_cause});
        pulse(PIN_STOP);
        wr_en(8'h7F);
        cur_low_any <= 1'b1;
        pulse(PIN_PRESS);
        cyc(4);
        chk_bit(1'b0, trip);
        cyc(30);
        chk_byte(cause(1), {2'h0, trip_cause});
        cur_low_any <= 1'b0;
        pulse(PIN_FRESET);
        ptc_over <= 1'b1;
        cyc(8);
        chk_byte(cause(3), {2'h0, trip_cause});
        // reset while the input is still hot: the trip must survive
        pulse(PIN_FRESET);
        chk_byte(cause(3), {2'h0, trip_cause});
        ptc_over <= 1'b0;
        pulse(PIN_FRESET);
        wr_en(8'h5F);
        ptc_over <= 1'b1;
        cyc(8);
        chk_bit(1'b0, trip);
        // let the cold level reach the synchroniser before re-enabling
        ptc_over <= 1'b0;
        cyc(4);
        wr_en(8'h7F);
        cur_present_any <= 1'b1;
        cyc(8);
        chk_byte(cause(2), {2'h0, trip_cause});
        chk_bit(1'b1, aux_relay);
        aux_relay_assignment <= 4'h3;
        cyc(2);
        chk_bit(1'b0, aux_relay);
        aux_relay_assignment <= 4'h7;
        cur_present_any <= 1'b0;
        pulse(PIN_FRESET);
        pulse(PIN_SCR);
        chk_bit(1'b1, scr_lock);
        pulse(PIN_PRESS);
        chk_bit(1'b0, run);
        pulse(PIN_FRESET);
        pulse(PIN_PRESS);
        pulse(PIN_SCR);
        chk_bit(1'b0, scr_lock);
        pulse(PIN_STOP);
        bypass <= 1'b1;
        pulse(PIN_SCR);
        chk_bit(1'b0, scr_lock);
        bypass <= 1'b0;
        line_ok_all <= 1'b0;
        cyc(8);
        chk_bit(1'b1, line_loss);
        pulse(PIN_PRESS);
        chk_bit(1'b0, run);
        line_ok_all <= 1'b1;
        cyc(8);
        chk_bit(1'b0, line_loss);
        chk_bit(1'b0, run);
        pulse(PIN_PRESS);
        chk_bit(1'b1, run);
        // hold the level first so 2-wire mode restarts the run two cycles after the mode change drops it
        want_run <= 1'b1;
        cyc(4);
        three_wire <= 1'b0;
        cyc(8);
        line_ok_all <= 1'b0;
        cyc(8);
        chk_bit(1'b0, run);
        line_ok_all <= 1'b1;
        cyc(8);
        chk_bit(1'b1, run);
        close_out();
    end
endmodule : testbench
